/* global_param_command_handler.sv */
// command interpreter for axis and global parameter access
// assumes: byte stream from a serial receiver on the same clock,
// a reply byte sink, an axis parameter source and a non-volatile store
//
// Overview of operation
// - instruction 6 reads selected axis parameter
// - direct mode axis read leaves accumulator unchanged
// - parameter reads reply status 100 with value
// - instruction 9 writes banks 0, 2, 3
// - bank 0 settings, 2 user, 3 interrupts
// - bank 0 writes also committed to store
// - instruction 10 copies global parameter to accumulator
// - parameter 66 bank 0 is bus address
// - instruction 11 saves user variable, replies OK
// - instruction 12 reloads user variable, replies OK
// - all user variables reloaded after power-up
// - reply frame nine bytes, success status 0x64
`timescale 1ns/10ps
`include "param_cmd_consts.svh"
module global_param_command_handler
  import param_cmd_pkg::*;
#(
  parameter int B0_DEPTH = 128,
  parameter int B2_DEPTH = 256,
  parameter int B3_DEPTH = 32,
  parameter logic [7:0] HOST_ADDR = `DEFAULT_HOST_ADDR,
  parameter logic [7:0] BUS_ADDR = `DEFAULT_BUS_ADDR,
  parameter bit AUTO_RELOAD = 1'b1
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // command byte stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  output logic o_rx_ready,
  // reply byte stream
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  // mode, accumulator and bus address
  input wire logic i_standalone,
  output logic [31:0] o_accum,
  output logic [7:0] o_bus_addr,
  // axis parameter source
  output logic o_axis_req,
  output logic [7:0] o_axis_type,
  output logic [7:0] o_axis_motor,
  input wire logic i_axis_done,
  input wire logic [31:0] i_axis_data,
  // non-volatile store
  output logic o_nv_req,
  output logic o_nv_we,
  output logic [7:0] o_nv_bank,
  output logic [7:0] o_nv_index,
  output logic [31:0] o_nv_wdata,
  input wire logic i_nv_done,
  input wire logic [31:0] i_nv_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    st_type st;
    logic [3:0] cnt;
    frame_type rx;
    frame_type tx;
    logic tx_valid;
    logic rx_ready;
    logic [31:0] accum;
    logic axis_req;
    logic nv_req;
    logic nv_we;
    logic [7:0] nv_bank;
    logic [7:0] nv_idx;
    logic [31:0] nv_wdata;
    logic [B0_DEPTH-1:0][31:0] b0;
    logic [B2_DEPTH-1:0][31:0] b2;
    logic [B3_DEPTH-1:0][31:0] b3;
  } state_type;

  state_type s_q;
  state_type s_d;
  cmd_type cmd;

  assign cmd = cmd_type'(s_q.rx[8:1]);

  function automatic frame_type make_reply(input logic [7:0] status, input logic [31:0] val);
    frame_type f;
    f = {HOST_ADDR, cmd.addr, status, cmd.instr, val, 8'h00};
    f[0] = frame_sum(f);
    return f;
  endfunction : make_reply

  function automatic logic type_ok(input logic [7:0] bank, input logic [7:0] t);
    int d;
    d = (bank == `BANK_SETTINGS) ? B0_DEPTH : (bank == `BANK_USER) ? B2_DEPTH : B3_DEPTH;
    return (32'(t) < d);
  endfunction : type_ok

  function automatic logic [31:0] get_param(input logic [7:0] bank, input logic [7:0] t);
    logic [31:0] v;
    v = 32'h0;
    if (bank == `BANK_SETTINGS) begin
      v = s_q.b0[t];
    end else if (bank == `BANK_USER) begin
      v = s_q.b2[t];
    end else begin
      v = s_q.b3[t];
    end
    return v;
  endfunction : get_param

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic bank_ok;
    bank_ok = 1'b0;
    s_d = s_q;
    bank_ok = (cmd.bank == `BANK_SETTINGS) || (cmd.bank == `BANK_USER)
      || (cmd.bank == `BANK_IRQ);
    unique case (s_q.st)
      ST_INIT: begin
        if (AUTO_RELOAD) begin
          s_d.nv_req = 1'b1;
          s_d.nv_we = 1'b0;
          s_d.nv_bank = `BANK_USER;
          s_d.st = ST_INIT_WAIT;
        end else begin
          s_d.st = ST_IDLE;
        end
      end
      ST_INIT_WAIT: begin
        if (i_nv_done) begin
          s_d.nv_req = 1'b0;
          s_d.b2[s_q.nv_idx] = i_nv_rdata;
          s_d.nv_idx = s_q.nv_idx + 8'h01;
          s_d.st = (32'(s_q.nv_idx) == B2_DEPTH - 1) ? ST_IDLE : ST_INIT;
          if (32'(s_q.nv_idx) == B2_DEPTH - 1) begin
            s_d.nv_idx = 8'h00;
          end
        end
      end
      ST_IDLE: begin
        if (i_rx_valid) begin
          s_d.rx = {s_q.rx[7:0], i_rx_byte};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == `FRAME_LAST) begin
            s_d.cnt = 4'h0;
            s_d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        s_d.st = ST_REPLY;
        s_d.tx_valid = 1'b1;
        if (cmd.addr != s_q.b0[`PARAM_BUS_ADDR][7:0]) begin
          s_d.tx_valid = 1'b0;
          s_d.st = ST_IDLE;
        end else if (frame_sum(s_q.rx) != s_q.rx[0]) begin
          s_d.tx = make_reply(`STATUS_BAD_CHECKSUM, 32'h0);
        end else begin
          unique case (cmd.instr)
            `INSTR_READ_AXIS: begin
              s_d.tx_valid = 1'b0;
              s_d.axis_req = 1'b1;
              s_d.st = ST_AXIS_WAIT;
            end
            `INSTR_WRITE_GLOBAL: begin
              if (!bank_ok) begin
                s_d.tx = make_reply(`STATUS_BAD_BANK, 32'h0);
              end else if (!type_ok(cmd.bank, cmd.ptype)) begin
                s_d.tx = make_reply(`STATUS_BAD_TYPE, 32'h0);
              end else begin
                if (cmd.bank == `BANK_SETTINGS) begin
                  s_d.b0[cmd.ptype] = cmd.value;
                  s_d.tx_valid = 1'b0;
                  s_d.nv_req = 1'b1;
                  s_d.nv_we = 1'b1;
                  s_d.nv_bank = cmd.bank;
                  s_d.nv_idx = cmd.ptype;
                  s_d.nv_wdata = cmd.value;
                  s_d.st = ST_NV_WAIT;
                end else if (cmd.bank == `BANK_USER) begin
                  s_d.b2[cmd.ptype] = cmd.value;
                end else begin
                  s_d.b3[cmd.ptype] = cmd.value;
                end
                s_d.tx = make_reply(`STATUS_OK, 32'h0);
              end
            end
            `INSTR_READ_GLOBAL: begin
              if (!bank_ok) begin
                s_d.tx = make_reply(`STATUS_BAD_BANK, 32'h0);
              end else if (!type_ok(cmd.bank, cmd.ptype)) begin
                s_d.tx = make_reply(`STATUS_BAD_TYPE, 32'h0);
              end else begin
                s_d.accum = get_param(cmd.bank, cmd.ptype);
                s_d.tx = make_reply(`STATUS_OK, get_param(cmd.bank, cmd.ptype));
              end
            end
            `INSTR_SAVE_USER, `INSTR_RELOAD_USER: begin
              if (cmd.bank != `BANK_USER) begin
                s_d.tx = make_reply(`STATUS_BAD_BANK, 32'h0);
              end else if (!type_ok(cmd.bank, cmd.ptype)) begin
                s_d.tx = make_reply(`STATUS_BAD_TYPE, 32'h0);
              end else begin
                s_d.tx_valid = 1'b0;
                s_d.nv_req = 1'b1;
                s_d.nv_we = (cmd.instr == `INSTR_SAVE_USER);
                s_d.nv_bank = `BANK_USER;
                s_d.nv_idx = cmd.ptype;
                s_d.nv_wdata = s_q.b2[cmd.ptype];
                s_d.st = ST_NV_WAIT;
              end
            end
            default: begin
              s_d.tx = make_reply(`STATUS_BAD_INSTR, 32'h0);
            end
          endcase
        end
      end
      ST_AXIS_WAIT: begin
        if (i_axis_done) begin
          s_d.axis_req = 1'b0;
          if (i_standalone) begin
            s_d.accum = i_axis_data;
          end
          s_d.tx = make_reply(`STATUS_OK, i_axis_data);
          s_d.tx_valid = 1'b1;
          s_d.st = ST_REPLY;
        end
      end
      ST_NV_WAIT: begin
        if (i_nv_done) begin
          s_d.nv_req = 1'b0;
          if (!s_q.nv_we) begin
            s_d.b2[s_q.nv_idx] = i_nv_rdata;
          end
          s_d.tx = make_reply(`STATUS_OK, 32'h0);
          s_d.tx_valid = 1'b1;
          s_d.st = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (i_tx_ready) begin
          s_d.tx = {s_q.tx[7:0], 8'h00};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == `FRAME_LAST) begin
            s_d.cnt = 4'h0;
            s_d.tx_valid = 1'b0;
            s_d.st = ST_IDLE;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.rx_ready = (s_d.st == ST_IDLE);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.b0[`PARAM_BUS_ADDR] <= {24'h0, BUS_ADDR};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rx_ready = s_q.rx_ready;
  assign o_tx_valid = s_q.tx_valid;
  assign o_tx_byte = s_q.tx[`FRAME_LAST];
  assign o_accum = s_q.accum;
  assign o_bus_addr = s_q.b0[`PARAM_BUS_ADDR][7:0];
  assign o_axis_req = s_q.axis_req;
  assign o_axis_type = cmd.ptype;
  assign o_axis_motor = cmd.bank;
  assign o_nv_req = s_q.nv_req;
  assign o_nv_we = s_q.nv_we;
  assign o_nv_bank = s_q.nv_bank;
  assign o_nv_index = s_q.nv_idx;
  assign o_nv_wdata = s_q.nv_wdata;

endmodule : global_param_command_handler

/* param_cmd_consts.svh */
// constants of the parameter command handler
// assumes: included by the package and the handler, nothing else
`ifndef PARAM_CMD_CONSTS_SVH
`define PARAM_CMD_CONSTS_SVH

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define INSTR_READ_AXIS 8'h06
`define INSTR_WRITE_GLOBAL 8'h09
`define INSTR_READ_GLOBAL 8'h0A
`define INSTR_SAVE_USER 8'h0B
`define INSTR_RELOAD_USER 8'h0C

// ----------------------------------------------------------------
// banks and special parameters
// ----------------------------------------------------------------
`define BANK_SETTINGS 8'h00
`define BANK_USER 8'h02
`define BANK_IRQ 8'h03
`define PARAM_BUS_ADDR 66

// ----------------------------------------------------------------
// reply status codes
// ----------------------------------------------------------------
`define STATUS_OK 8'h64
`define STATUS_BAD_CHECKSUM 8'h01
`define STATUS_BAD_INSTR 8'h02
`define STATUS_BAD_TYPE 8'h03
`define STATUS_BAD_BANK 8'h04

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define FRAME_BYTES 4'h9
`define FRAME_LAST 4'h8
`define DEFAULT_BUS_ADDR 8'h01
`define DEFAULT_HOST_ADDR 8'h02

`endif

/* param_cmd_pkg.sv */
// types shared by the parameter command handler
// assumes: param_cmd_consts.svh on the include path
package param_cmd_pkg;
  `include "param_cmd_consts.svh"

  // ----------------------------------------------------------------
  // frame and state types
  // ----------------------------------------------------------------
  typedef logic [8:0][7:0] frame_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] instr;
    logic [7:0] ptype;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_type;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_INIT_WAIT,
    ST_IDLE,
    ST_EXEC,
    ST_AXIS_WAIT,
    ST_NV_WAIT,
    ST_REPLY
  } st_type;

  // modulo-256 sum of the eight leading bytes
  function automatic logic [7:0] frame_sum(input frame_type f);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 1; i < 9; i++) begin
      s = s + f[i];
    end
    return s;
  endfunction : frame_sum

endpackage : param_cmd_pkg

/* param_cmd_monitor.sv */
// port checker of the parameter command handler
// assumes: bound to the handler, sees its ports only
`timescale 1ns/10ps
module param_cmd_monitor (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // inputs watched
  input wire logic i_tx_ready,
  input wire logic i_standalone,
  input wire logic i_axis_done,
  input wire logic [31:0] i_axis_data,
  input wire logic i_nv_done,
  // outputs watched
  input wire logic o_rx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic [31:0] o_accum,
  input wire logic o_axis_req,
  input wire logic [7:0] o_axis_type,
  input wire logic o_nv_req,
  input wire logic o_nv_we,
  input wire logic [7:0] o_nv_bank
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  AST_NV_HOLD: assert property (o_nv_req && !i_nv_done |=> o_nv_req && $stable(o_nv_bank))
    else $error("store request dropped early");
  AST_AXIS_HOLD: assert property (o_axis_req && !i_axis_done |=> o_axis_req && $stable(o_axis_type))
    else $error("axis request dropped early");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("reply byte changed before taken");
  AST_RX_QUIET: assert property (o_tx_valid || o_nv_req || o_axis_req |-> !o_rx_ready)
    else $error("command bytes taken while busy");
  AST_DIRECT_ACC: assert property (o_axis_req && i_axis_done && !i_standalone |=> $stable(o_accum))
    else $error("direct axis read changed accumulator");
  AST_AXIS_ACC: assert property (o_axis_req && i_axis_done && i_standalone |=> o_accum == $past(i_axis_data))
    else $error("standalone axis read not in accumulator");
  AST_AXIS_REPLY: assert property (o_axis_req && i_axis_done |=> o_tx_valid && !o_axis_req)
    else $error("no reply after axis read");
  AST_NV_BANK: assert property (o_nv_req |-> (o_nv_we ? o_nv_bank != 8'h03 : o_nv_bank == 8'h02))
    else $error("store access to wrong bank");
endmodule : param_cmd_monitor
bind global_param_command_handler param_cmd_monitor chk (.*);

/* nv_axis_model.sv */
// non-volatile store and axis source beside the handler
// assumes: same clock and reset as the handler
`timescale 1ns/10ps
module nv_axis_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // store side
  input wire logic i_nv_req,
  input wire logic i_nv_we,
  input wire logic [7:0] i_nv_bank,
  input wire logic [7:0] i_nv_index,
  input wire logic [31:0] i_nv_wdata,
  output logic o_nv_done,
  output logic [31:0] o_nv_rdata,
  // axis side
  input wire logic i_axis_req,
  input wire logic [7:0] i_axis_type,
  output logic o_axis_done,
  output logic [31:0] o_axis_data
);
  logic [31:0] mem [512];
  logic [7:0] noise_q;
  logic [1:0] wait_q;
  logic slow_q;
  logic [8:0] key;
  initial for (int i = 0; i < 512; i++) mem[i] = 32'hA0000000 | i;
  assign key = {i_nv_bank[1], i_nv_index};
  // data only valid with done, otherwise a changing pattern
  assign o_nv_rdata = o_nv_done ? mem[key] : {4{noise_q}};
  assign o_axis_data = o_axis_done ? {16'hBEEF, i_axis_type, 8'h00} : ~{4{noise_q}};
  // answers alternate between prompt and slow
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_nv_done <= 1'b0;
      o_axis_done <= 1'b0;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
      noise_q <= 8'h00;
    end else begin
      noise_q <= noise_q + 8'h3B;
      if (o_nv_done || o_axis_done) begin
        o_nv_done <= 1'b0;
        o_axis_done <= 1'b0;
        wait_q <= 2'h0;
      end else if ((i_nv_req || i_axis_req) && wait_q == {slow_q, 1'b0}) begin
        o_nv_done <= i_nv_req;
        o_axis_done <= i_axis_req;
        slow_q <= ~slow_q;
        if (i_nv_req && i_nv_we) mem[key] <= i_nv_wdata;
      end else if (i_nv_req || i_axis_req) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : nv_axis_model

/* global_param_command_handler_tb_top.sv */
// self-checking bench of the parameter command handler
// assumes: handler, monitor and store model compiled before it
`timescale 1ns/10ps
module global_param_command_handler_tb_top;
  import param_cmd_pkg::*;
  typedef struct {logic [7:0] ins, typ, bnk; logic [31:0] val; logic [7:0] st;
    logic [31:0] exp; bit cv;} row_type;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_rx_valid = 1'b0, i_tx_ready = 1'b0;
  logic i_standalone = 1'b0, o_rx_ready, o_tx_valid, o_axis_req, o_nv_req, o_nv_we;
  logic i_axis_done, i_nv_done;
  logic [7:0] i_rx_byte = 8'h00, o_tx_byte, o_bus_addr, o_axis_type, o_axis_motor;
  logic [7:0] o_nv_bank, o_nv_index;
  logic [31:0] o_accum, i_axis_data, o_nv_wdata, i_nv_rdata;
  logic [7:0] r [9];
  int err_total = 0, checks = 0, cyc = 0;
  bit seen;
  row_type rows [15] = '{
    '{8'h09, 8'h05, 8'h00, 32'h12345678, 8'h64, 32'h0, 1'h0},
    '{8'h0A, 8'h05, 8'h00, 32'h0, 8'h64, 32'h12345678, 1'h1},
    '{8'h09, 8'h01, 8'h02, 32'hCAFE0001, 8'h64, 32'h0, 1'h0},
    '{8'h0B, 8'h01, 8'h02, 32'h0, 8'h64, 32'h0, 1'h0},
    '{8'h09, 8'h01, 8'h02, 32'h0, 8'h64, 32'h0, 1'h0},
    '{8'h0C, 8'h01, 8'h02, 32'h0, 8'h64, 32'h0, 1'h0},
    '{8'h0A, 8'h01, 8'h02, 32'h0, 8'h64, 32'hCAFE0001, 1'h1},
    '{8'h09, 8'h03, 8'h03, 32'h77, 8'h64, 32'h0, 1'h0},
    '{8'h0A, 8'h03, 8'h03, 32'h0, 8'h64, 32'h77, 1'h1},
    '{8'h0A, 8'h00, 8'h02, 32'h0, 8'h64, 32'hA0000100, 1'h1},
    '{8'h09, 8'h00, 8'h01, 32'h5, 8'h04, 32'h0, 1'h1},
    '{8'h0B, 8'h01, 8'h00, 32'h0, 8'h04, 32'h0, 1'h1},
    '{8'h07, 8'h00, 8'h00, 32'h0, 8'h02, 32'h0, 1'h1},
    '{8'h0A, 8'h04, 8'h02, 32'h0, 8'h03, 32'h0, 1'h1},
    '{8'h06, 8'h01, 8'h00, 32'h0, 8'h64, 32'hBEEF0100, 1'h1}};

  global_param_command_handler #(.B2_DEPTH(4)) dut (.*);
  nv_axis_model m (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_nv_req(o_nv_req),
    .i_nv_we(o_nv_we), .i_nv_bank(o_nv_bank), .i_nv_index(o_nv_index),
    .i_nv_wdata(o_nv_wdata), .o_nv_done(i_nv_done), .o_nv_rdata(i_nv_rdata),
    .i_axis_req(o_axis_req), .i_axis_type(o_axis_type), .o_axis_done(i_axis_done),
    .o_axis_data(i_axis_data));

  always #5 i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] a, ins, typ, bnk, input logic [31:0] v,
      input logic [7:0] bump);
    logic [7:0] f [9];
    f = '{a, ins, typ, bnk, v[31:24], v[23:16], v[15:8], v[7:0], bump};
    for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
    for (int i = 0; i < 9; i++) begin
      i_rx_valid <= 1'b1;
      i_rx_byte <= f[i];
      do @(posedge i_ref_clk); while (o_rx_ready !== 1'b1);
    end
    i_rx_valid <= 1'b0;
  endtask : send

  // sink stalls every other cycle
  task automatic get;
    int n;
    n = 0;
    while (n < 9) begin
      @(posedge i_ref_clk);
      if (i_tx_ready && o_tx_valid) begin
        r[n] = o_tx_byte;
        n++;
      end
      i_tx_ready <= ~i_tx_ready & (n < 9);
    end
  endtask : get

  task automatic cmd(input logic [7:0] a, ins, typ, bnk, input logic [31:0] v);
    send(a, ins, typ, bnk, v, 8'h00);
    get();
  endtask : cmd

  task automatic chk_reply(input logic [7:0] a, ins, st, input logic [31:0] v, input bit cv);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + r[i];
    chk(r[0], 8'h02);
    chk(r[1], a);
    chk(r[2], st);
    chk(r[3], ins);
    if (cv) chk({r[4], r[5], r[6], r[7]}, v);
    chk(r[8], s);
  endtask : chk_reply

  task automatic wait_ready;
    for (int n = 0; n < 300 && o_rx_ready !== 1'b1; n++) @(posedge i_ref_clk);
    chk(o_rx_ready, 1'b1);
  endtask : wait_ready

  task automatic results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge i_ref_clk);
    chk(o_bus_addr, 8'h01);
    chk(o_accum, 32'h0);
    i_reset <= 1'b0;
    wait_ready();
    foreach (rows[k]) begin
      cmd(8'h01, rows[k].ins, rows[k].typ, rows[k].bnk, rows[k].val);
      chk_reply(8'h01, rows[k].ins, rows[k].st, rows[k].exp, rows[k].cv);
      if (rows[k].ins == 8'h0A && rows[k].st == 8'h64) chk(o_accum, rows[k].exp);
    end
    chk(o_accum, 32'hA0000100);
    chk(m.mem[9'h005], 32'h12345678);
    chk(m.mem[9'h101], 32'hCAFE0001);
    send(8'h01, 8'h0A, 8'h05, 8'h00, 32'h0, 8'h01);
    get();
    chk(r[2], 8'h01);
    i_standalone <= 1'b1;
    cmd(8'h01, 8'h06, 8'h02, 8'h00, 32'h0);
    chk(o_accum, 32'hBEEF0200);
    chk(o_axis_type, 8'h02);
    chk(o_axis_motor, 8'h00);
    i_standalone <= 1'b0;
    cmd(8'h01, 8'h09, 8'h42, 8'h00, 32'h3);
    chk(o_bus_addr, 8'h03);
    chk(m.mem[9'h042], 32'h3);
    send(8'h01, 8'h0A, 8'h42, 8'h00, 32'h0, 8'h00);
    seen = 1'b0;
    repeat (30) begin
      @(posedge i_ref_clk);
      seen |= o_tx_valid;
    end
    chk(seen, 1'b0);
    cmd(8'h03, 8'h0A, 8'h42, 8'h00, 32'h0);
    chk_reply(8'h03, 8'h0A, 8'h64, 32'h3, 1'b1);
    cmd(8'h03, 8'h09, 8'h01, 8'h02, 32'h0);
    chk(r[2], 8'h64);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    chk(o_bus_addr, 8'h01);
    i_reset <= 1'b0;
    wait_ready();
    cmd(8'h01, 8'h0A, 8'h01, 8'h02, 32'h0);
    chk_reply(8'h01, 8'h0A, 8'h64, 32'hCAFE0001, 1'b1);
    results();
  end
endmodule : global_param_command_handler_tb_top
